// ---- dsh_top.sv ----
/*
 dsh_top: dma status and slave handshake pins of a system peripheral.
 assumes a single 40 MHz clock; status, ready, start, command, write, address and data pins are synchronised here; the
 bus controller decodes the status codes; the dma engine supplies the
 transfer request, timing, width and end/page-break flags on ref_clk.
 falling-edge timing is modelled as one clock of this fast clock.
*/
`timescale 1ns/10ps

// Contract
// RL1: low status pair carries timing type
// RL2: upper status pair carries slave width
// RL3: timing pair changes only at phase edges
// RL4: width pair leaves/returns idle at edges
// RL5: status lines driven only when mastering
// RL6: strobe rise latches address, mem/io, write
// RL7: latched mem/io one is memory
// RL8: acknowledge line sampled at t2
// RL9: master keeps acknowledge stable at t2
// RL10: cycle-in-progress sampled every rising edge
// RL11: controller builds commands from status
// RL12: ready low only for long isa cycles
// RL13: ready low four clocks then high
// RL14: ready driver on at t2, off on release
// RL15: ready sampled 2.5 periods for pipelining
// RL16: pipelining stops at page or end
// RL17: ready sampled until idle, once more
// RL18: data driven on select io read/ack
// RL19: select from t2, released by command
// RL20: select active on every acknowledge
// RL21: address enable low while dma/refresh owns
// RL22: reset at least eight clocks, clears all
// RL23: master/slave state steers pin direction
module dsh_top
	import dsh_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        dma_grant,
	input  wire logic        refresh_run,
	input  wire logic        xfer_req,
	input  wire logic [1:0]  xfer_timing,
	input  wire logic [1:0]  xfer_width,
	input  wire logic        xfer_last,
	input  wire logic        page_break,
	input  wire logic [3:0]  cycle_kind_lines_in,
	output logic      [3:0]  cycle_kind_lines_out,
	output logic             cycle_kind_lines_oe,
	input  wire logic        ready_handshake_line_in,
	output logic             ready_handshake_line_out,
	output logic             ready_handshake_line_oe,
	input  wire logic [13:0] host_addr_lines,
	input  wire logic        host_write_read,
	input  wire logic        start_n,
	input  wire logic        cmd_n,
	input  wire logic        isa_master,
	input  wire logic        long_cmd,
	input  wire logic        addr_hit,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	output logic             slave_select_out_n,
	output logic             address_enable_out_n,
	output logic             pipe_active,
	output logic             dma_ready,
	output logic             bus_cycle_active,
	output logic      [13:0] latched_addr,
	output logic             latched_mem,
	output logic             latched_write,
	output logic      [7:0]  write_data,
	output logic             write_strobe
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read only by second
	// every pin costs two clocks of latency; against the much slower
	// bus clock that still leaves the t2 decode inside one bus phase
	logic [3:0]  st_s1_r, st_s2_r;   // status lines
	logic [3:0]  ctl_s1_r, ctl_s2_r; // ready, start, cmd, write
	logic [13:0] a_s1_r, a_s2_r;     // host address
	logic [7:0]  d_s1_r, d_s2_r;     // data in

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_s1_r  <= 4'hF;
			st_s2_r  <= 4'hF;
			ctl_s1_r <= 4'hF;
			ctl_s2_r <= 4'hF;
			a_s1_r   <= 14'h0000;
			a_s2_r   <= 14'h0000;
			d_s1_r   <= 8'h00;
			d_s2_r   <= 8'h00;
		end else begin
			st_s1_r  <= cycle_kind_lines_in;
			st_s2_r  <= st_s1_r;
			ctl_s1_r <= {ready_handshake_line_in, start_n, cmd_n, host_write_read};
			ctl_s2_r <= ctl_s1_r;
			a_s1_r   <= host_addr_lines;
			a_s2_r   <= a_s1_r;
			d_s1_r   <= data_in;
			d_s2_r   <= d_s1_r;
		end
	end

	wire rdy_s   = ctl_s2_r[3]; // synchronised ready
	wire start_s = ctl_s2_r[2]; // synchronised start, low active
	wire cmd_s   = ctl_s2_r[1]; // synchronised command, low active
	wire wr_s    = ctl_s2_r[0]; // synchronised write/read

	////////////////////////////////////////////////////////////////////////
	// state registers
	// all state below is cleared by the synchronous reset
	dsh_mstate_t ms_r, ms_nxt;          // master phase
	logic        mst_r, mst_nxt;        // master owns pins
	logic [1:0]  tim_r, tim_nxt;        // timing pair
	logic [1:0]  wid_r, wid_nxt;        // width pair
	logic [1:0]  chk_r, chk_nxt;        // pipelining check delay
	logic        pipe_r, pipe_nxt;      // pipelining
	logic        rdyq_r, rdyq_nxt;      // dma ready pulse
	logic        aen_r, aen_nxt;        // address enable, low active
	logic        cip_r, cip_nxt;        // cycle in progress seen
	logic        stb_q_r, stb_q_nxt;    // previous strobe level
	logic [13:0] la_r, la_nxt;          // latched address
	logic        lm_r, lm_nxt;          // latched mem/io
	logic        lw_r, lw_nxt;          // latched write/read
	logic        t2_pend_r, t2_pend_nxt;// start seen, t2 next
	logic [7:0]  wd_r, wd_nxt;          // write data
	logic        ws_r, ws_nxt;          // write strobe
	logic        cmd_q_r, cmd_q_nxt;    // previous command level

	dsh_slave_if sif();

	// t2 is the edge after start; slave decode only when not mastering
	wire t2_now   = t2_pend_r & ~mst_r;
	wire ack_now  = ~st_s2_r[ST_ACK_BIT];       // RL8
	wire cmd_rise = cmd_s & ~cmd_q_r;
	// strobe rising edge seen this cycle, slave side only
	wire stb_rise = ~mst_r & st_s2_r[ST_STROBE_BIT] & ~stb_q_r; // RL6
	// the latch is transparent: in the cycle of the strobe rise the
	// cycle kind comes straight from the synchronisers, so a t2 in that same
	// cycle never decodes the previous cycle's mem/io or write
	wire mem_now  = stb_rise ? st_s2_r[ST_MEMIO_BIT] : lm_r; // RL7
	wire wr_now   = stb_rise ? wr_s : lw_r;                  // RL6

	assign sif.t2_hit   = t2_now & (ack_now | addr_hit);  // RL20
	assign sif.is_ack   = ack_now;                        // RL8
	assign sif.is_io_rd = ~mem_now & ~wr_now;             // RL7 RL18
	assign sif.isa_long = isa_master & long_cmd & ~ack_now; // RL12
	// taking ownership ends any slave cycle, so the ready driver is
	// already off when the status lines turn around
	assign sif.cmd_off  = cmd_rise | mst_nxt;             // RL14 RL19 RL23

	dsh_slave_eng u_slave (
		.ref_clk (ref_clk),
		.reset   (reset),
		.sif     (sif)
	);

	////////////////////////////////////////////////////////////////////////
	// master sequence and slave latching
	// one transfer: a request in idle moves the width off idle at the
	// next edge, ready is checked three edges later for pipelining,
	// then sampled every edge until the last transfer or a page break;
	// a pipelined transfer waits for ready once more before idle
	always_comb begin
		ms_nxt      = ms_r;
		tim_nxt     = tim_r;
		wid_nxt     = wid_r;
		chk_nxt     = chk_r;
		pipe_nxt    = pipe_r;
		rdyq_nxt    = 1'b0;
		la_nxt      = la_r;
		lm_nxt      = lm_r;
		lw_nxt      = lw_r;
		wd_nxt      = wd_r;
		ws_nxt      = 1'b0;
		mst_nxt     = dma_grant | refresh_run;           // RL23
		aen_nxt     = ~(dma_grant | refresh_run);        // RL21
		cip_nxt     = ~st_s2_r[ST_CIP_BIT];              // RL10
		stb_q_nxt   = st_s2_r[ST_STROBE_BIT];
		cmd_q_nxt   = cmd_s;
		t2_pend_nxt = ~start_s & ~mst_r;
		// slave: strobe rising edge latches cycle info
		// address and kind then hold until the next strobe rise
		if (stb_rise) begin
			la_nxt = a_s2_r;                    // RL6
			lm_nxt = st_s2_r[ST_MEMIO_BIT];     // RL6 RL7
			lw_nxt = wr_s;                      // RL6
		end
		// slave i/o write takes data at command release
		// data pins are synchronised like the rest, so this is the value
		// that stood two clocks before the release was seen
		if (!mst_r && cmd_rise && u_slave_sel() && !lm_r && lw_r) begin
			wd_nxt = d_s2_r;                    // RL18
			ws_nxt = 1'b1;
		end
		case (ms_r)
			DSH_M_IDLE: begin
				// width idle whenever no transfer runs
				wid_nxt = SIZE_IDLE;
				if (mst_r && xfer_req) begin
					tim_nxt = xfer_timing;      // RL1 RL3
					wid_nxt = xfer_width;       // RL2 RL4
					chk_nxt = PIPE_CHECK_CLKS;
					ms_nxt  = DSH_M_CHECK;
				end
			end
			DSH_M_CHECK: begin
				// count down to the pipelining sample
				chk_nxt = chk_r - 2'h1;
				if (chk_r == 2'h1) begin
					pipe_nxt = rdy_s & (tim_r == TIM_BURST); // RL15
					ms_nxt   = DSH_M_XFER;
				end
			end
			DSH_M_XFER: begin
				// ready sampled on every rising edge
				rdyq_nxt = rdy_s;               // RL17
				if (page_break || xfer_last || !mst_r) begin
					pipe_nxt = 1'b0;            // RL16
					wid_nxt  = SIZE_IDLE;       // RL4
					ms_nxt   = pipe_r ? DSH_M_LAST : DSH_M_IDLE;
				end
			end
			default: begin
				// one more ready after idle closes the last cycle
				if (rdy_s) begin
					rdyq_nxt = 1'b1;            // RL17
					ms_nxt   = DSH_M_IDLE;
				end
			end
		endcase
	end

	// select as seen by the write capture
	function automatic logic u_slave_sel();
		return sif.sel;
	endfunction

	// registers only; reset clears every state machine
	// limitation: the command release is seen two clocks late rather
	// than asynchronously, so select and ready drop later than the pin
	always_ff @(posedge ref_clk) begin
		if (reset) begin                        // RL22
			ms_r      <= DSH_M_IDLE;
			mst_r     <= 1'b0;
			tim_r     <= TIM_COMPAT;
			wid_r     <= SIZE_IDLE;
			chk_r     <= 2'h0;
			pipe_r    <= 1'b0;
			rdyq_r    <= 1'b0;
			aen_r     <= 1'b1;
			cip_r     <= 1'b0;
			stb_q_r   <= 1'b1;
			la_r      <= 14'h0000;
			lm_r      <= 1'b0;
			lw_r      <= 1'b0;
			t2_pend_r <= 1'b0;
			wd_r      <= 8'h00;
			ws_r      <= 1'b0;
			cmd_q_r   <= 1'b1;
		end else begin
			ms_r      <= ms_nxt;
			mst_r     <= mst_nxt;
			tim_r     <= tim_nxt;
			wid_r     <= wid_nxt;
			chk_r     <= chk_nxt;
			pipe_r    <= pipe_nxt;
			rdyq_r    <= rdyq_nxt;
			aen_r     <= aen_nxt;
			cip_r     <= cip_nxt;
			stb_q_r   <= stb_q_nxt;
			la_r      <= la_nxt;
			lm_r      <= lm_nxt;
			lw_r      <= lw_nxt;
			t2_pend_r <= t2_pend_nxt;
			wd_r      <= wd_nxt;
			ws_r      <= ws_nxt;
			cmd_q_r   <= cmd_q_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin outputs, all from flip-flops
	// the inversions sit straight behind their flip-flops and add no
	// logic depth; data_out is constant because register contents
	// live outside this block
	assign cycle_kind_lines_out     = {wid_r, tim_r};     // RL1 RL2
	assign cycle_kind_lines_oe      = mst_r;              // RL5 RL23
	assign ready_handshake_line_out = sif.rdy_out;
	assign ready_handshake_line_oe  = sif.rdy_oe;         // RL14 RL23
	assign data_out                 = 8'hFF;
	assign data_oe                  = sif.data_oe;        // RL18
	assign slave_select_out_n       = ~sif.sel;
	assign address_enable_out_n     = aen_r;              // RL21
	assign pipe_active              = pipe_r;
	assign dma_ready                = rdyq_r;
	assign bus_cycle_active         = cip_r;
	assign latched_addr             = la_r;
	assign latched_mem              = lm_r;
	assign latched_write            = lw_r;
	assign write_data               = wd_r;
	assign write_strobe             = ws_r;
endmodule

// ---- dsh_pkg.sv ----
/*
 dsh_pkg: constants for the dma status / slave handshake block.
 assumes one 40 MHz bus-side clock and a synchronous active-high reset.
*/
package dsh_pkg;
	// clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS   = 25000;
	// timing-type codes on the low status pair
	localparam logic [1:0]  TIM_COMPAT      = 2'h0;
	localparam logic [1:0]  TIM_TYPE_A      = 2'h1;
	localparam logic [1:0]  TIM_TYPE_B      = 2'h2;
	localparam logic [1:0]  TIM_BURST       = 2'h3;
	// width codes on the upper status pair
	localparam logic [1:0]  SIZE_8          = 2'h0;
	localparam logic [1:0]  SIZE_16         = 2'h1;
	localparam logic [1:0]  SIZE_32         = 2'h2;
	localparam logic [1:0]  SIZE_IDLE       = 2'h3;
	// field positions inside the status lines
	localparam int unsigned ST_STROBE_BIT   = 0;
	localparam int unsigned ST_MEMIO_BIT    = 1;
	localparam int unsigned ST_ACK_BIT      = 2;
	localparam int unsigned ST_CIP_BIT      = 3;
	// ready held low for this many clocks after t2
	localparam logic [2:0]  READY_LOW_CLKS  = 3'h4;
	// pipelining check: 2.5 periods after leaving idle, taken as 3 rising edges
	localparam int unsigned PIPE_CHECK_X10  = 25;
	localparam logic [1:0]  PIPE_CHECK_CLKS = 2'((PIPE_CHECK_X10 + 9) / 10);
	// minimum reset length in clocks
	localparam logic [3:0]  RESET_MIN_CLKS  = 4'h8;
	// master phase states
	typedef enum logic [1:0] {
		DSH_M_IDLE  = 2'b00,
		DSH_M_CHECK = 2'b01,
		DSH_M_XFER  = 2'b10,
		DSH_M_LAST  = 2'b11
	} dsh_mstate_t;
endpackage

// ---- dsh_slave_if.sv ----
/*
 dsh_slave_if: slave-side decode results passed from the top to the slave engine.
 assumes both ends run on ref_clk.
*/
`timescale 1ns/10ps
interface dsh_slave_if;
	logic       t2_hit;     // t2 edge of a cycle aimed at this device
	logic       is_ack;     // acknowledge cycle sampled at t2
	logic       is_io_rd;   // i/o read
	logic       isa_long;   // isa master, long command
	logic       cmd_off;    // command release seen, or pins owned as master
	logic       sel;        // slave select active
	logic       rdy_oe;     // ready driver enabled
	logic       rdy_out;    // ready level
	logic       data_oe;    // data bus driven
	modport top (output t2_hit, is_ack, is_io_rd, isa_long, cmd_off,
		input sel, rdy_oe, rdy_out, data_oe);
	modport eng (input t2_hit, is_ack, is_io_rd, isa_long, cmd_off,
		output sel, rdy_oe, rdy_out, data_oe);
endinterface

// ---- dsh_slave_eng.sv ----
/*
 dsh_slave_eng: slave select, ready hold and data drive during slave cycles.
 assumes the top has synchronised the command strobe and built the t2 decode.
*/
`timescale 1ns/10ps
module dsh_slave_eng
	import dsh_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset,
	dsh_slave_if.eng  sif
);
	logic       sel_r,  sel_nxt;   // slave select
	logic       oe_r,   oe_nxt;    // ready driver enable
	logic       lo_r,   lo_nxt;    // ready held low
	logic       drv_r,  drv_nxt;   // data drive
	logic [2:0] cnt_r,  cnt_nxt;   // ready low counter

	////////////////////////////////////////////////////////////////////////
	// next state; command release wins over everything
	always_comb begin
		sel_nxt = sel_r;
		oe_nxt  = oe_r;
		lo_nxt  = lo_r;
		drv_nxt = drv_r;
		cnt_nxt = cnt_r;
		if (sif.cmd_off) begin
			// release ends the cycle
			sel_nxt = 1'b0; // RL19
			oe_nxt  = 1'b0; // RL14
			lo_nxt  = 1'b0;
			drv_nxt = 1'b0;
			cnt_nxt = 3'h0;
		end else if (sif.t2_hit) begin
			sel_nxt = 1'b1; // RL19 RL20
			oe_nxt  = 1'b1; // RL14
			lo_nxt  = sif.isa_long; // RL12
			cnt_nxt = READY_LOW_CLKS;
			drv_nxt = sif.is_io_rd | sif.is_ack; // RL18
		end else if (lo_r) begin
			// count down, then ready goes high on a rising edge
			cnt_nxt = cnt_r - 3'h1; // RL13
			if (cnt_r == 3'h1)
				lo_nxt = 1'b0; // RL13
		end
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sel_r <= 1'b0;
			oe_r  <= 1'b0;
			lo_r  <= 1'b0;
			drv_r <= 1'b0;
			cnt_r <= 3'h0;
		end else begin
			sel_r <= sel_nxt;
			oe_r  <= oe_nxt;
			lo_r  <= lo_nxt;
			drv_r <= drv_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign sif.sel     = sel_r;
	assign sif.rdy_oe  = oe_r;
	assign sif.rdy_out = ~lo_r;
	// drv_r only ever rises with select and falls with it
	assign sif.data_oe = drv_r; // RL18
endmodule

// ---- dsh_props.sv ----
/*
 dsh_props: pin assertions for dsh_top, bound below.
 assumes the bench resolves the two-way pins.
*/
`timescale 1ns/10ps
module dsh_props
	import dsh_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        xfer_req,
	input wire logic [3:0]  cycle_kind_lines_in,
	input wire logic [3:0]  cycle_kind_lines_out,
	input wire logic        cycle_kind_lines_oe,
	input wire logic        ready_handshake_line_out,
	input wire logic        ready_handshake_line_oe,
	input wire logic [13:0] host_addr_lines,
	input wire logic        start_n,
	input wire logic        cmd_n,
	input wire logic        isa_master,
	input wire logic        long_cmd,
	input wire logic        addr_hit,
	input wire logic        data_oe,
	input wire logic        slave_select_out_n,
	input wire logic        address_enable_out_n,
	input wire logic        pipe_active,
	input wire logic [13:0] latched_addr,
	input wire logic        latched_write
);
	// single domain, reset masks all but the reset check
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	a_reset_idle:
	assert property (disable iff (1'b0) reset |=> !cycle_kind_lines_oe
		&& slave_select_out_n && address_enable_out_n) else $error("pins active in reset");
	a_width_start:
	assert property ($rose(xfer_req) && cycle_kind_lines_oe && cycle_kind_lines_out[3:2] == SIZE_IDLE
		|=> cycle_kind_lines_out[3:2] != SIZE_IDLE) else $error("width stayed idle");
	a_timing_hold:
	assert property (cycle_kind_lines_out[3:2] != SIZE_IDLE && $past(cycle_kind_lines_out[3:2])
		!= SIZE_IDLE |-> $stable(cycle_kind_lines_out[1:0])) else $error("timing moved");
	a_pipe_burst:
	assert property ($rose(pipe_active) |-> cycle_kind_lines_out[1:0] == TIM_BURST)
		else $error("pipelining outside burst");
	a_ready_isa:
	assert property (ready_handshake_line_oe && !ready_handshake_line_out |-> isa_master
		&& long_cmd) else $error("ready low for short cycle");
	a_ready_hold:
	assert property ($fell(ready_handshake_line_out) |-> (!ready_handshake_line_out)[*4]
		##1 ready_handshake_line_out) else $error("ready low length wrong");
	a_sel_t2:
	assert property ($fell(start_n) && (addr_hit || !cycle_kind_lines_in[2]) && !cycle_kind_lines_oe
		|-> slave_select_out_n[*2] ##[1:5] !slave_select_out_n) else $error("select timing");
	a_sel_release:
	assert property ($rose(cmd_n) && !slave_select_out_n |-> ##[1:4] (slave_select_out_n
		&& !data_oe && !ready_handshake_line_oe)) else $error("select not released");
	a_data_dir:
	assert property (data_oe |-> !slave_select_out_n && !latched_write)
		else $error("data driven outside read");
	a_addr_latch:
	assert property ($rose(cycle_kind_lines_in[0]) && !cycle_kind_lines_oe && !$past(cycle_kind_lines_oe)
		|-> ##[1:4] latched_addr == host_addr_lines) else $error("address not latched");
	// main scenarios reached
	c_pipe: cover property (pipe_active);
	c_ready_low: cover property ($fell(ready_handshake_line_out));
	c_data_out: cover property (data_oe);
endmodule

bind dsh_top dsh_props u_props (.*);

// ---- dsh_bus_model.sv ----
/*
 dsh_bus_model: bus controller and host side of the status, ready,
 start, command, address and data pins.
 assumes the bench resolves pins; released lines read as pulled up.
*/
`timescale 1ns/10ps
module dsh_bus_model
	import dsh_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic [3:0]  st_pin,
	output logic      [3:0]  st_drv,
	output logic             rdy_drv,
	output logic      [13:0] host_addr_lines,
	output logic             host_write_read,
	output logic             start_n,
	output logic             cmd_n,
	output logic      [7:0]  dat
);
	int slow = 0; // clocks of ready low per transfer
	int cnt = 0;  // clocks since width left idle
	initial begin
		st_drv = 4'hF;
		rdy_drv = 1'b1;
		host_addr_lines = 14'h0;
		host_write_read = 1'b0;
		start_n = 1'b1;
		cmd_n = 1'b1;
		dat = 8'hA5;
	end
	////////////////////////////////////////
	// ready paced from the width code; idle reads as the pull-up
	always @(posedge ref_clk) begin
		#1;
		cnt = (st_pin[3:2] != SIZE_IDLE) ? cnt + 1 : 0;
		rdy_drv = (cnt == 0) || (cnt > slow);
	end
	// one slave cycle; acknowledge held stable across t2
	task automatic cyc(input logic [13:0] a, input logic m, w, k, input logic [7:0] d);
		@(posedge ref_clk) #1;
		host_addr_lines = a;
		host_write_read = w;
		st_drv = {1'b0, !k, m, 1'b0};
		start_n = 1'b0;
		@(posedge ref_clk) #1;
		st_drv[0] = 1'b1;
		start_n = 1'b1;
		cmd_n = 1'b0;
		dat = w ? d : ~dat;
		repeat (10) @(posedge ref_clk);
		#1 cmd_n = 1'b1;
		st_drv[2] = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 st_drv[3] = 1'b1;
		host_addr_lines = ~a;
		dat = ~dat;
	endtask
endmodule

// ---- tb.sv ----
/*
 tb: self-checking bench for dsh_top with the bus-side model.
 assumes 40 MHz ref_clk; stimulus lands 1 ns after each rising edge.
*/
`timescale 1ns/10ps
module tb
	import dsh_pkg::*;
();
	logic        ref_clk, reset, dma_grant, refresh_run, xfer_req, xfer_last, page_break;
	logic        isa_master, long_cmd, addr_hit, rdy_drv, host_write_read, start_n, cmd_n;
	logic        cycle_kind_lines_oe, ready_handshake_line_out, ready_handshake_line_oe;
	logic        data_oe, slave_select_out_n, address_enable_out_n, pipe_active;
	logic        dma_ready, bus_cycle_active, latched_mem, latched_write, write_strobe;
	logic [1:0]  xfer_timing, xfer_width;
	logic [3:0]  st_drv, cycle_kind_lines_out;
	logic [7:0]  dat, data_out, write_data, wd;
	logic [13:0] host_addr_lines, latched_addr;
	wire  [3:0]  cycle_kind_lines_in;
	wire         ready_handshake_line_in;
	wire  [7:0]  data_in;
	int          fail_count, checked, rlow, selc, doe, drc, pipc, cipc;
	// wire levels from every party's enable
	assign cycle_kind_lines_in = cycle_kind_lines_oe ? cycle_kind_lines_out : st_drv;
	assign ready_handshake_line_in = ready_handshake_line_oe ? ready_handshake_line_out : rdy_drv;
	assign data_in = data_oe ? data_out : dat;
	dsh_top uut (.*);
	dsh_bus_model u_bus (.st_pin(cycle_kind_lines_in), .*);
	always #12.5 ref_clk = ~ref_clk;
	////////////////////////////////////////
	// settled-output monitor, sampled mid-cycle
	always @(negedge ref_clk) begin
		if (ready_handshake_line_oe === 1'b1 && ready_handshake_line_out === 1'b0) rlow++;
		if (slave_select_out_n === 1'b0) selc++;
		if (data_oe === 1'b1) doe++;
		if (dma_ready === 1'b1) drc++;
		if (pipe_active === 1'b1) pipc++;
		if (bus_cycle_active === 1'b1) cipc++;
		if (write_strobe === 1'b1) wd = write_data;
	end
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ownership by grant or refresh; o is 1 while owned
	task automatic own(input logic o);
		repeat (3) @(posedge ref_clk);
		#1 chk({cycle_kind_lines_oe, address_enable_out_n}, {o, !o});
	endtask
	// one transfer; s clocks of slow ready, ep expected pipelining, pb ends by page break
	task automatic t_master(input logic [1:0] t, w, input int s, input logic ep, pb);
		int i;
		u_bus.slow = s;
		{rlow, selc, doe, drc, pipc, cipc} = '0;
		dma_grant = 1'b1;
		xfer_timing = t;
		xfer_width = w;
		own(1'b1);
		xfer_req = 1'b1;
		@(posedge ref_clk) #1 xfer_req = 1'b0;
		#5 chk(cycle_kind_lines_out, {w, t});
		repeat (8) @(posedge ref_clk);
		#1 {page_break, xfer_last} = {pb, !pb};
		for (i = 0; i < 20 && cycle_kind_lines_out[3:2] !== SIZE_IDLE; i++) @(posedge ref_clk) #1;
		for (i = 0; i < 20 && pipe_active !== 1'b0; i++) @(posedge ref_clk) #1;
		chk(cycle_kind_lines_out[3:2], SIZE_IDLE);
		chk({pipe_active, pipc != 0}, {1'b0, ep});
		chk(drc != 0, 1'b1);
		{page_break, xfer_last} = 2'h0;
		dma_grant = 1'b0;
		own(1'b0);
		$display("test master %0d %0d done", t, s);
	endtask
	// one slave cycle; er ready-low clocks, ed data expected out
	task automatic t_slave(input logic [13:0] a, input logic m, w, k, i, l, h,
		input logic [7:0] d, input logic [2:0] er, input logic ed);
		{rlow, selc, doe, drc, pipc, cipc} = '0;
		isa_master = i;
		long_cmd = l;
		addr_hit = h;
		u_bus.cyc(a, m, w, k, d);
		chk(latched_addr, a);
		chk({latched_mem, latched_write}, {m, w});
		chk({slave_select_out_n, selc != 0}, 2'h3);
		chk(16'(rlow), er);
		chk({doe != 0, cipc != 0}, {ed, 1'b1});
		if (w) chk(wd, d);
		$display("test slave %h done", a);
	endtask
	// run: reset, master codes, refresh, slave kinds
	initial begin
		{ref_clk, dma_grant, refresh_run, xfer_req, xfer_last, page_break} = '0;
		{isa_master, long_cmd, addr_hit, xfer_timing, xfer_width} = '0;
		reset = 1'b1;
		repeat (16) @(posedge ref_clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 chk({cycle_kind_lines_oe, ready_handshake_line_oe, data_oe}, 3'h0);
		chk({slave_select_out_n, address_enable_out_n, cycle_kind_lines_out}, 6'h3C);
		chk(data_out, 8'hFF);
		$display("test reset done");
		for (int n = 0; n < 4; n++) t_master(2'(n), 2'(n % 3), 0, n == 3, 1'b0);
		t_master(TIM_BURST, SIZE_32, 5, 1'b0, 1'b0);
		t_master(TIM_BURST, SIZE_16, 0, 1'b1, 1'b1);
		refresh_run = 1'b1;
		own(1'b1);
		refresh_run = 1'b0;
		own(1'b0);
		$display("test refresh done");
		t_slave(14'h1A5, 0, 0, 0, 1, 1, 1, 8'h00, 3'h4, 1);
		t_slave(14'h2C3, 0, 1, 0, 1, 0, 1, 8'h5A, 3'h0, 0);
		t_slave(14'h0F0, 0, 0, 0, 0, 1, 1, 8'h00, 3'h0, 1);
		t_slave(14'h3FC, 1, 0, 0, 0, 1, 1, 8'h00, 3'h0, 0);
		t_slave(14'h010, 0, 0, 1, 0, 0, 0, 8'h00, 3'h0, 1);
		conclude();
	end
	// watchdog well past the expected run
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule
